/* hdl/mmc_pkg.sv */
// Constants, types and memory map of the module management block
package mmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_HZ = 10000000; // System clock rate
	localparam int CLK_NS = 100; // Clock period in ns
	localparam int RESET_MIN_NS = 10000; // Shortest honoured reset pulse
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_MAX_MS = 2000; // Longest power-on init time
	localparam int INIT_CYC = INIT_MAX_MS * (CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////
	// Serial slave address and memory map
	localparam logic [6:0] DEV_ADDR = 7'h50; // Plain default address
	localparam logic [7:0] REG_STATUS = 8'h00; // Init pending flag
	localparam logic [7:0] REG_FLAGS = 8'h01; // Sticky events, clear on read
	localparam logic [7:0] REG_CONTROL = 8'h02; // Software controls
	localparam logic [7:0] REG_MON_BASE = 8'h03; // Lane power, 8 bytes
	localparam logic [7:0] MON_BYTES = 8'h08; // Two bytes per lane
	localparam int STATUS_INIT_BIT = 0; // Init pending
	localparam int FLAG_RESET_BIT = 0; // Reset complete
	localparam int FLAG_LOS_BIT = 1; // Receive loss seen
	localparam int FLAG_FAULT_BIT = 2; // Operational fault seen
	localparam int CTRL_TXDIS_BIT = 0; // Software transmit disable
	localparam logic [7:0] CTRL_RESET = 8'h00; // Control default
	localparam logic [2:0] FLAGS_RESET = 3'h0; // Flags default
	localparam logic [3:0] BYTE_BITS = 4'h8; // Bits in a serial byte

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser layout and idle values
	localparam int SYNC_W = 10; // sel_n, rst_n, lp, txdis, scl, sda, los
	localparam logic [9:0] SYNC_INIT = 10'h330; // Idle pin levels

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		MMC_IDLE = 3'b000,
		MMC_ADDR = 3'b001,
		MMC_ACK_A = 3'b010,
		MMC_WRITE = 3'b011,
		MMC_ACK_W = 3'b100,
		MMC_READ = 3'b101,
		MMC_RD_ACK = 3'b110
	} mmc_state_t;

	typedef struct packed {
		logic [3:0][15:0] power; // Received power per lane
	} mmc_monitor_t;

endpackage

/* hdl/mmc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module mmc_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1; // Metastable stage, read only by s2
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_dout;

	////////////////////////////////////////////////////////////////////////
	// Accept a bit only when stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (srst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			dout <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule

/* hdl/mmc_mgmt_ctrl.sv */
// Management and control pin logic of a four-lane optical module
`timescale 1ns/100ps
// Summary of operation
// - Serve serial bus only while selected
// - Long reset pulse restores all defaults
// - Completion: attention low, init pending clear
// - Power-up raises completion attention unprompted
// - Attention low flags fault or critical status
// - Pin or software bit disables transmitter
// - Any lane below threshold raises loss alarm
// - Four lane powers readable over serial bus
// - Low-power select caps module power
// - Presence pin pulled low when inserted
// - Serial clock and data reach memory map
// - Init completes within bounded time
module mmc_mgmt_ctrl #(
	parameter int RESET_MIN_CYCLES = mmc_pkg::RESET_MIN_CYC,
	parameter int INIT_CYCLES = mmc_pkg::INIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	input wire logic transmit_disable,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [3:0] lane_below_threshold,
	input wire logic module_fault,
	input wire mmc_pkg::mmc_monitor_t optical_monitor,
	output logic sda_out,
	output logic sda_oe_n,
	output logic attention_n_out,
	output logic attention_oe_n,
	output logic presence_n_out,
	output logic presence_oe_n,
	output logic tx_output_off,
	output logic receive_signal_loss,
	output logic power_cap
);
	////////////////////////////////////////////////////////////////////////
	// Synchronised pins
	logic [mmc_pkg::SYNC_W-1:0] pins; // Filtered pin levels
	logic sel_n_s, rst_n_s, lp_s, txdis_s, scl_s, sda_s;
	logic [3:0] los_s;
	logic scl_q, sda_q; // Previous filtered levels for edge detect

	mmc_pin_sync #(.WIDTH(mmc_pkg::SYNC_W), .INIT(mmc_pkg::SYNC_INIT)) u_sync (
		.clk(clk),
		.srst(srst),
		.din({module_select_n, module_reset_n, low_power_select,
			transmit_disable, scl_in, sda_in, lane_below_threshold}),
		.dout(pins)
	);
	assign {sel_n_s, rst_n_s, lp_s, txdis_s, scl_s, sda_s, los_s} = pins;

	wire selected = ~sel_n_s;
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_seen = scl_s & scl_q & sda_q & ~sda_s; // Data falls, clock high
	wire stop_seen = scl_s & scl_q & ~sda_q & sda_s; // Data rises, clock high

	////////////////////////////////////////////////////////////////////////
	// Reset pulse filter and initialisation timer
	logic [15:0] rst_cnt, next_rst_cnt; // Cycles the reset pin has been low
	logic [24:0] init_cnt, next_init_cnt;
	logic init_pending, next_init_pending;
	logic pin_reset; // Qualified long reset pulse
	logic hw_rst; // Power-up or qualified pin reset
	logic done_evt; // One-cycle pulse at init completion
	localparam logic [15:0] RMIN = 16'(RESET_MIN_CYCLES);
	localparam logic [24:0] ILAST = 25'(INIT_CYCLES - 1);

	// Pin reset counts only once held for the full minimum
	assign pin_reset = ~rst_n_s & (rst_cnt == RMIN);
	assign hw_rst = srst | pin_reset;

	always_comb begin
		next_rst_cnt = rst_n_s ? 16'h0000 : rst_cnt;
		if (!rst_n_s && rst_cnt != RMIN) begin
			next_rst_cnt = rst_cnt + 16'h0001;
		end
		next_init_cnt = init_cnt;
		next_init_pending = init_pending;
		done_evt = 1'b0;
		if (hw_rst) begin
			next_init_cnt = 25'h0000000;
			next_init_pending = 1'b1;
		end else if (init_pending) begin
			// Ends at the bound, never later
			if (init_cnt == ILAST) begin
				next_init_pending = 1'b0;
				done_evt = 1'b1;
			end else begin
				next_init_cnt = init_cnt + 25'h0000001;
			end
		end
	end

	// Counter registers
	always_ff @(posedge clk) begin
		if (srst) begin
			rst_cnt <= 16'h0000;
			init_cnt <= 25'h0000000;
			init_pending <= 1'b1;
		end else begin
			rst_cnt <= next_rst_cnt;
			init_cnt <= next_init_cnt;
			init_pending <= next_init_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial slave state
	mmc_pkg::mmc_state_t state, next_state;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] sh, next_sh; // Shift register, both directions
	logic [7:0] ptr, next_ptr; // Memory map pointer
	logic [7:0] ctrl, next_ctrl; // Software control byte
	logic [2:0] flags, next_flags; // Sticky events
	logic rw, next_rw, first, next_first, nack, next_nack;
	logic sda_drive, next_drive; // High while pulling data low
	logic do_load; // Fetch a byte for the host
	logic [7:0] rd_byte;

	// Memory map read decode
	function automatic logic [7:0] read_map(input logic [7:0] a,
		input logic pend, input logic [2:0] fl, input logic [7:0] c,
		input mmc_pkg::mmc_monitor_t m);
		logic [7:0] idx;
		logic [15:0] w;
		idx = a - mmc_pkg::REG_MON_BASE;
		w = m.power[idx[2:1]];
		if (a == mmc_pkg::REG_STATUS) begin
			read_map = {7'h00, pend};
		end else if (a == mmc_pkg::REG_FLAGS) begin
			read_map = {5'h00, fl};
		end else if (a == mmc_pkg::REG_CONTROL) begin
			read_map = c;
		end else if (idx < mmc_pkg::MON_BYTES) begin
			read_map = idx[0] ? w[7:0] : w[15:8];
		end else begin
			read_map = 8'h00; // Unmapped reads as zero
		end
	endfunction

	assign rd_byte = read_map(ptr, init_pending, flags, ctrl, optical_monitor);

	// Byte protocol: address, pointer, data, acknowledge
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_sh = sh;
		next_ptr = ptr;
		next_ctrl = ctrl;
		next_rw = rw;
		next_first = first;
		next_nack = nack;
		next_drive = sda_drive;
		do_load = 1'b0;
		if (!selected) begin
			next_state = mmc_pkg::MMC_IDLE;
			next_drive = 1'b0;
		end else if (start_seen) begin
			next_state = mmc_pkg::MMC_ADDR;
			next_bitcnt = 4'h0;
			next_drive = 1'b0;
		end else if (stop_seen) begin
			next_state = mmc_pkg::MMC_IDLE;
			next_drive = 1'b0;
		end else if (scl_rise) begin
			unique case (state)
				mmc_pkg::MMC_ADDR, mmc_pkg::MMC_WRITE: begin
					next_sh = {sh[6:0], sda_s};
					next_bitcnt = bitcnt + 4'h1;
				end
				mmc_pkg::MMC_READ: next_bitcnt = bitcnt + 4'h1;
				mmc_pkg::MMC_RD_ACK: next_nack = sda_s;
				mmc_pkg::MMC_IDLE, mmc_pkg::MMC_ACK_A, mmc_pkg::MMC_ACK_W: ;
			endcase
		end else if (scl_fall) begin
			unique case (state)
				mmc_pkg::MMC_ADDR: begin
					if (bitcnt == mmc_pkg::BYTE_BITS) begin
						// Own address only; others go idle
						if (sh[7:1] == mmc_pkg::DEV_ADDR) begin
							next_drive = 1'b1;
							next_rw = sh[0];
							next_state = mmc_pkg::MMC_ACK_A;
						end else begin
							next_state = mmc_pkg::MMC_IDLE;
						end
					end
				end
				mmc_pkg::MMC_ACK_A: begin
					next_drive = 1'b0;
					next_bitcnt = 4'h0;
					next_first = 1'b1;
					next_state = mmc_pkg::MMC_WRITE;
					do_load = rw;
				end
				mmc_pkg::MMC_WRITE: begin
					if (bitcnt == mmc_pkg::BYTE_BITS) begin
						next_drive = 1'b1;
						next_state = mmc_pkg::MMC_ACK_W;
						next_first = 1'b0;
						if (first) begin
							next_ptr = sh;
						end else begin
							if (ptr == mmc_pkg::REG_CONTROL) begin
								next_ctrl = sh;
							end
							next_ptr = ptr + 8'h01;
						end
					end
				end
				mmc_pkg::MMC_ACK_W: begin
					next_drive = 1'b0;
					next_bitcnt = 4'h0;
					next_state = mmc_pkg::MMC_WRITE;
				end
				mmc_pkg::MMC_READ: begin
					if (bitcnt == mmc_pkg::BYTE_BITS) begin
						next_drive = 1'b0; // Let host acknowledge
						next_state = mmc_pkg::MMC_RD_ACK;
					end else begin
						next_drive = ~sh[6];
						next_sh = {sh[6:0], 1'b0};
					end
				end
				mmc_pkg::MMC_RD_ACK: begin
					next_state = mmc_pkg::MMC_IDLE;
					do_load = ~nack; // Host wants another byte
				end
				mmc_pkg::MMC_IDLE: ;
			endcase
		end
		if (do_load) begin
			next_sh = rd_byte;
			next_drive = ~rd_byte[7];
			next_ptr = ptr + 8'h01;
			next_bitcnt = 4'h0;
			next_state = mmc_pkg::MMC_READ;
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_comb begin
		next_flags = flags;
		if (do_load && ptr == mmc_pkg::REG_FLAGS) begin
			next_flags = mmc_pkg::FLAGS_RESET;
		end
		next_flags[mmc_pkg::FLAG_RESET_BIT] = next_flags[0] | done_evt;
		next_flags[mmc_pkg::FLAG_LOS_BIT] = next_flags[1] | (|los_s);
		next_flags[mmc_pkg::FLAG_FAULT_BIT] = next_flags[2] | module_fault;
	end

	// Serial and map registers; a long reset pin restores defaults
	always_ff @(posedge clk) begin
		if (hw_rst) begin
			state <= mmc_pkg::MMC_IDLE;
			bitcnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			ctrl <= mmc_pkg::CTRL_RESET;
			flags <= mmc_pkg::FLAGS_RESET;
			rw <= 1'b0;
			first <= 1'b0;
			nack <= 1'b0;
			sda_drive <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			sh <= next_sh;
			ptr <= next_ptr;
			ctrl <= next_ctrl;
			flags <= next_flags;
			rw <= next_rw;
			first <= next_first;
			nack <= next_nack;
			sda_drive <= next_drive;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pins, all registered
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			attention_n_out <= 1'b0;
			attention_oe_n <= 1'b1;
			presence_n_out <= 1'b0;
			presence_oe_n <= 1'b0;
			tx_output_off <= 1'b1;
			receive_signal_loss <= 1'b0;
			power_cap <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			sda_out <= 1'b0;
			sda_oe_n <= hw_rst ? 1'b1 : ~next_drive;
			attention_n_out <= 1'b0;
			// Open drain: low only while an event is pending
			attention_oe_n <= hw_rst ? 1'b1 : ~(|next_flags);
			presence_n_out <= 1'b0;
			presence_oe_n <= 1'b0;
			tx_output_off <= txdis_s |
				(~pin_reset & next_ctrl[mmc_pkg::CTRL_TXDIS_BIT]);
			receive_signal_loss <= |los_s;
			power_cap <= lp_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_unselected_quiet: assert property (!selected |=> sda_oe_n)
		else $error("data driven while not selected");
	chk_reset_long: assert property ((!rst_n_s && rst_cnt == RMIN) |=>
		init_pending && ctrl == mmc_pkg::CTRL_RESET)
		else $error("long reset did not restore defaults");
	chk_reset_short: assert property ($rose(pin_reset) |->
		$past(rst_cnt) == RMIN - 16'h0001)
		else $error("reset honoured before minimum length");
	chk_done_attention: assert property ($fell(init_pending) && !hw_rst |->
		!attention_oe_n && flags[mmc_pkg::FLAG_RESET_BIT])
		else $error("completion not flagged on attention");
	chk_powerup_init: assert property ($fell(srst) |-> init_pending)
		else $error("power-up did not start initialisation");
	chk_init_bound: assert property (init_pending |->
		init_cnt <= ILAST)
		else $error("initialisation overran its bound");
	chk_fault_attn: assert property (module_fault && !pin_reset |=>
		!attention_oe_n ##1 !attention_oe_n)
		else $error("fault did not hold attention low");
	chk_tx_off: assert property (txdis_s |=> tx_output_off)
		else $error("transmitter not disabled by pin");
	chk_loss_alarm: assert property ((|los_s) && !pin_reset |=>
		receive_signal_loss && flags[mmc_pkg::FLAG_LOS_BIT])
		else $error("loss alarm missing");
	chk_monitor_read: assert property (do_load && !hw_rst &&
		ptr == mmc_pkg::REG_MON_BASE |=>
		sh == $past(optical_monitor.power[0][15:8]))
		else $error("lane power byte not loaded");
	chk_low_power: assert property (lp_s |=> power_cap)
		else $error("low power select not applied");
	chk_presence_low: assert property (!presence_oe_n)
		else $error("presence not pulled low");
	chk_addr_ack: assert property (state == mmc_pkg::MMC_ACK_A &&
		selected |-> !sda_oe_n)
		else $error("address not acknowledged");

	cov_pin_reset: cover property ($rose(pin_reset));
	cov_init_done: cover property ($fell(init_pending));
	cov_read_byte: cover property (state == mmc_pkg::MMC_RD_ACK);
	cov_ctrl_write: cover property ($changed(ctrl));
endmodule

/* bench/mmc_host_model.sv */
// Host board controller model for the two-wire management bus
`timescale 1ns/100ps
module mmc_host_model #(
	parameter int HALF = 12
) (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull,
	output logic sel_n
);
	// Bus released and module deselected at start
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		sel_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Whole clock cycles, all changes land just after an edge
	task automatic hw(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Own select line for this module only
	task automatic set_sel(input logic v);
		hw(1);
		sel_n <= v;
	endtask

	// Data set while clock low, sampled mid high phase
	task automatic hbit(input logic b, output logic r);
		hw(1);
		sda_pull <= ~b;
		hw(HALF);
		scl <= 1'b1;
		hw(HALF / 2);
		r = sda_line;
		hw(HALF / 2);
		scl <= 1'b0;
	endtask

	// Start, also usable as repeated start
	task automatic hstart();
		hw(1);
		sda_pull <= 1'b0;
		hw(HALF);
		scl <= 1'b1;
		hw(HALF);
		sda_pull <= 1'b1;
		hw(HALF);
		scl <= 1'b0;
	endtask

	// Stop leaves both lines released
	task automatic hstop();
		hw(1);
		sda_pull <= 1'b1;
		hw(HALF);
		scl <= 1'b1;
		hw(HALF);
		sda_pull <= 1'b0;
		hw(HALF);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Byte out, MSB first, ack sampled in ninth slot
	task automatic hsend(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) hbit(d[i], r);
		hbit(1'b1, r);
		ack = ~r;
	endtask

	// Byte in; last byte is answered with a nack
	task automatic hrecv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			hbit(1'b1, r);
			d[i] = r;
		end
		hbit(last, r);
	endtask

	// Pointer then one data byte
	task automatic reg_write(input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic a0, a1, a2;
		hstart();
		hsend({mmc_pkg::DEV_ADDR, 1'b0}, a0);
		hsend(p, a1);
		hsend(d, a2);
		hstop();
		ok = a0 & a1 & a2;
	endtask

	// Pointer, repeated start, n bytes packed first byte highest
	task automatic reg_read(input logic [7:0] p, input int n,
		output logic [63:0] d, output logic ok);
		logic a0, a1, a2;
		logic [7:0] b;
		d = '0;
		hstart();
		hsend({mmc_pkg::DEV_ADDR, 1'b0}, a0);
		hsend(p, a1);
		hstart();
		hsend({mmc_pkg::DEV_ADDR, 1'b1}, a2);
		for (int i = 0; i < n; i++) begin
			hrecv(i == n - 1, b);
			d = {d[55:0], b};
		end
		hstop();
		ok = a0 & a1 & a2;
	endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the management control pin block
`timescale 1ns/100ps
module tb_top;
	localparam int RMIN = 8; // Short reset minimum keeps runs brief
	localparam int INIT = 50; // Short init time
	logic clk, srst, module_reset_n, low_power_select, transmit_disable;
	logic module_fault, sda_out, sda_oe_n, attention_n_out;
	logic attention_oe_n, presence_n_out, presence_oe_n;
	logic tx_output_off, receive_signal_loss, power_cap;
	logic scl, sda_pull, sel_n;
	logic [3:0] lane_below_threshold;
	mmc_pkg::mmc_monitor_t optical_monitor;
	int n_fail = 0;
	int checked = 0;
	// Open-drain wires with host pull-ups
	wire sda_wire = ~sda_pull & (sda_oe_n | sda_out);
	wire att_n = attention_oe_n | attention_n_out;
	wire pres_n = presence_oe_n | presence_n_out;

	////////////////////////////////////////////////////////////////////////
	mmc_mgmt_ctrl #(.RESET_MIN_CYCLES(RMIN), .INIT_CYCLES(INIT))
		mmc_mgmt_ctrl_i (.clk(clk), .srst(srst),
		.module_select_n(sel_n), .module_reset_n(module_reset_n),
		.low_power_select(low_power_select),
		.transmit_disable(transmit_disable), .scl_in(scl),
		.sda_in(sda_wire), .lane_below_threshold(lane_below_threshold),
		.module_fault(module_fault), .optical_monitor(optical_monitor),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.attention_n_out(attention_n_out),
		.attention_oe_n(attention_oe_n), .presence_n_out(presence_n_out),
		.presence_oe_n(presence_oe_n), .tx_output_off(tx_output_off),
		.receive_signal_loss(receive_signal_loss), .power_cap(power_cap));
	mmc_host_model host_i (.clk(clk), .sda_line(sda_wire), .scl(scl),
		.sda_pull(sda_pull), .sel_n(sel_n));

	////////////////////////////////////////////////////////////////////////
	// Clock at 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Closing report, the only exit
	task automatic tally_and_finish();
		$display("Checks made %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Four-state compare so unknowns never match
	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hw(input int n);
		repeat (n) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Completion attention in bounded time, then read its cause
	task automatic t_boot();
		int n;
		logic [63:0] d;
		logic ok;
		n = 0;
		while (att_n !== 1'b0 && n < INIT + 20) begin
			@(posedge clk);
			n++;
		end
		check("init not early", n >= INIT - 2, 1'b1);
		check("init in time", n < INIT + 20, 1'b1);
		if (n >= INIT + 20) begin
			tally_and_finish();
		end else begin
			host_i.reg_read(mmc_pkg::REG_STATUS, 1, d, ok);
			check("init pending", d, 64'h0);
			host_i.reg_read(mmc_pkg::REG_FLAGS, 1, d, ok);
			check("reset flag", d, 64'h1);
			check("read acks", ok, 1'b1);
			hw(4);
			check("attention off", att_n, 1'b1);
		end
	endtask

	// Deselected module ignores a control write
	task automatic t_select();
		logic ok;
		host_i.set_sel(1'b1);
		hw(8);
		host_i.reg_write(mmc_pkg::REG_CONTROL, 8'h01, ok);
		check("deselected ack", ok, 1'b0);
		check("deselected tx", tx_output_off, 1'b0);
		host_i.set_sel(1'b0);
		hw(8);
	endtask

	// Pin, software bit, or both switch transmitter off
	task automatic t_txdis();
		logic ok;
		for (int i = 0; i < 4; i++) begin
			host_i.reg_write(mmc_pkg::REG_CONTROL, {7'h00, i[0]}, ok);
			transmit_disable <= i[1];
			hw(8);
			check("tx off", tx_output_off, i[0] | i[1]);
		end
		host_i.reg_write(mmc_pkg::REG_CONTROL, 8'h00, ok);
		transmit_disable <= 1'b0;
	endtask

	// Every lane pattern, then the latched cause
	task automatic t_los();
		logic [63:0] d;
		logic ok;
		for (int p = 0; p < 16; p++) begin
			lane_below_threshold <= p[3:0];
			hw(8);
			check("loss alarm", receive_signal_loss, |p[3:0]);
		end
		lane_below_threshold <= 4'h0;
		hw(8);
		check("loss attention", att_n, 1'b0);
		host_i.reg_read(mmc_pkg::REG_FLAGS, 1, d, ok);
		check("loss flag", d, 64'h2);
	endtask

	// One-cycle fault pulse is latched and flagged
	task automatic t_fault();
		logic [63:0] d;
		logic ok;
		module_fault <= 1'b1;
		hw(1);
		module_fault <= 1'b0;
		hw(4);
		check("fault attention", att_n, 1'b0);
		host_i.reg_read(mmc_pkg::REG_FLAGS, 1, d, ok);
		check("fault flag", d, 64'h4);
		hw(4);
		check("fault cleared", att_n, 1'b1);
	endtask

	// Foreign address refused; other registers only move the pointer
	task automatic t_decode();
		logic [63:0] d;
		logic ok, a0, a1;
		host_i.hstart();
		host_i.hsend({mmc_pkg::DEV_ADDR ^ 7'h01, 1'b0}, a0);
		host_i.hsend(mmc_pkg::REG_CONTROL, a1);
		host_i.hstop();
		check("foreign address", a0, 1'b0);
		check("foreign pointer", a1, 1'b0);
		// Write to status must not land, pointer still advances
		host_i.reg_write(mmc_pkg::REG_STATUS, 8'hff, ok);
		check("status write ack", ok, 1'b1);
		// Two bytes: status then empty flags, host acks the first
		host_i.reg_read(mmc_pkg::REG_STATUS, 2, d, ok);
		check("status untouched", d, 64'h0);
		host_i.reg_read(8'h40, 1, d, ok);
		check("unmapped read", d, 64'h0);
		check("unmapped ack", ok, 1'b1);
	endtask

	// Lane powers in lane order, high byte first
	task automatic t_monitor();
		logic [63:0] d;
		logic ok;
		optical_monitor <= 64'hcdef_89ab_4567_0123;
		hw(2);
		host_i.reg_read(mmc_pkg::REG_MON_BASE, 8, d, ok);
		check("lane powers", d, 64'h0123_4567_89ab_cdef);
	endtask

	// Low-power pin drives the power cap both ways
	task automatic t_lowpower();
		for (int v = 1; v >= 0; v--) begin
			low_power_select <= v[0];
			hw(8);
			check("power cap", power_cap, v[0]);
		end
	endtask

	// Short pulse ignored, long pulse restores defaults
	task automatic t_reset();
		logic [63:0] d;
		logic ok;
		host_i.reg_write(mmc_pkg::REG_CONTROL, 8'h01, ok);
		module_reset_n <= 1'b0;
		hw(RMIN - 2);
		module_reset_n <= 1'b1;
		hw(INIT + 10);
		host_i.reg_read(mmc_pkg::REG_CONTROL, 1, d, ok);
		check("short pulse", d, 64'h1);
		check("no restart", att_n, 1'b1);
		module_reset_n <= 1'b0;
		hw(RMIN + 8);
		module_reset_n <= 1'b1;
		t_boot();
		host_i.reg_read(mmc_pkg::REG_CONTROL, 1, d, ok);
		check("control default", d, 64'h0);
		check("tx back on", tx_output_off, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		srst = 1'b1;
		module_reset_n = 1'b1;
		low_power_select = 1'b0;
		transmit_disable = 1'b0;
		module_fault = 1'b0;
		lane_below_threshold = 4'h0;
		optical_monitor = '0;
		host_i.set_sel(1'b0);
		hw(16);
		srst <= 1'b0;
		check("presence", pres_n, 1'b0);
		t_boot();
		t_select();
		t_txdis();
		t_los();
		t_fault();
		t_decode();
		t_monitor();
		t_lowpower();
		t_reset();
		tally_and_finish();
	end
endmodule
